// File: inc/tfs_params.svh
// register offsets, reset values and the reserved rate source code for the tdm frame sync control bank
`ifndef TFS_PARAMS_SVH
`define TFS_PARAMS_SVH
`define TFS_ADDR_W 10
`define TFS_A_SAT1_PHASE 10'h224
`define TFS_A_SAT2_STATE 10'h225
`define TFS_A_SAT2_MISS 10'h226
`define TFS_A_SAT2_MCRE 10'h228
`define TFS_A_SAT2_MCIM 10'h229
`define TFS_A_SAT2_PCRE 10'h22a
`define TFS_A_SAT2_PCIM 10'h22b
`define TFS_A_SAT2_PHASE 10'h22c
`define TFS_A_TERR_EN 10'h22d
`define TFS_A_TERR_WIN 10'h22e
`define TFS_A_TERR_PTHR 10'h22f
`define TFS_A_TERR_STHR 10'h230
`define TFS_A_TERR_SLEN 10'h231
`define TFS_A_TERR_FOUND 10'h232
`define TFS_A_TERR_LOSS 10'h233
`define TFS_A_TERR_POLYL 10'h234
`define TFS_A_TERR_POLYH 10'h235
`define TFS_A_TERR_FMT 10'h236
`define TFS_A_TERR_STATE 10'h237
`define TFS_A_TERR_FCNT 10'h239
`define TFS_A_TERR_MCRE 10'h23a
`define TFS_A_TERR_MCIM 10'h23b
`define TFS_A_TERR_PHASE 10'h23c
`define TFS_A_TERR_FALLB 10'h23f
`define TFS_A_SAT_WEN 10'h240
`define TFS_A_SAT_WST 10'h241
`define TFS_A_RATE_CTRL 10'h250
`define TFS_R_TERR_EN 5'h1f
`define TFS_R_TERR_WIN 4'h7
`define TFS_R_TERR_PTHR 7'h2c
`define TFS_R_TERR_STHR 7'h28
`define TFS_R_TERR_SLEN 5'h03
`define TFS_R_TERR_FOUND 4'h2
`define TFS_R_TERR_LOSS 4'hb
`define TFS_R_TERR_POLYL 8'h05
`define TFS_R_TERR_POLYH 4'h8
`define TFS_R_TERR_FMT 4'h0
`define TFS_R_TERR_FALLB 1'h1
`define TFS_R_SAT_WEN 8'hff
`define TFS_R_RATE_CTRL 3'h0
`define TFS_RATE_SRC_RFU 2'h3
`endif

// File: inc/tfs_pkg.sv
// types shared by the tdm frame sync control bank
package tfs_pkg;
   // satellite branch two sync status
   typedef struct packed {
      logic [1:0] search;
      logic [1:0] dropout;
      logic [1:0] status;
      logic lock;
   } tfs_sat_state_t;
   // correlation results of one branch
   typedef struct packed {
      logic [7:0] marker_re;
      logic [7:0] marker_im;
      logic [6:0] pattern_re;
      logic [6:0] pattern_im;
   } tfs_corr_t;
   // terrestrial format control
   typedef struct packed {
      logic map_invert;
      logic offset_binary;
      logic limiter;
      logic quadrature_swap;
   } tfs_format_t;
   // terrestrial sync status codes
   typedef enum logic [1:0] {
      TFS_T_IDLE = 2'h0,
      TFS_T_PRESYNC = 2'h1,
      TFS_T_SYNC = 2'h2,
      TFS_T_UNLOCK = 2'h3
   } tfs_terr_status_t;
   // terrestrial tracker states, one-hot
   typedef enum logic [2:0] {
      TFS_ST_HUNT = 3'h1,
      TFS_ST_PRE = 3'h2,
      TFS_ST_LOCK = 3'h4
   } tfs_track_t;
endpackage : tfs_pkg

// File: rtl/tfs_frame_sync_ctrl.sv
// tdm frame sync control and status register bank with terrestrial sync tracker
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "tfs_params.svh"
`default_nettype none
module tfs_frame_sync_ctrl #(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register port
   input wire logic [`TFS_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // satellite status from the decoder
   input wire tfs_pkg::tfs_sat_state_t sat2_state_in,
   input wire logic [3:0] sat2_miss_in,
   input wire tfs_pkg::tfs_corr_t sat2_corr_in,
   input wire logic [1:0] sat1_phase_in,
   input wire logic [1:0] sat2_phase_in,
   input wire logic [1:0] sat_invalid_pattern,
   input wire logic [1:0] sat_cycle_slip,
   input wire logic [1:0] sat_weight_active,
   // terrestrial stream
   input wire logic terr_marker_slot,
   input wire logic terr_in_window,
   input wire logic [6:0] terr_corr_mag,
   input wire logic [7:0] terr_corr_re,
   input wire logic [7:0] terr_corr_im,
   input wire logic [1:0] terr_phase_in,
   input wire logic terr_data_valid,
   input wire logic [DATA_W-1:0] terr_data_i,
   input wire logic [DATA_W-1:0] terr_data_q,
   // controls out
   output logic [4:0] terr_enables,
   output logic [3:0] terr_window_width,
   output logic [11:0] terr_poly,
   output logic terr_restart_search,
   output logic [DATA_W-1:0] terr_out_i,
   output logic [DATA_W-1:0] terr_out_q,
   output logic terr_out_valid,
   output logic [1:0] sat_weight_zero,
   output logic [1:0] sat_weight_fifo_enable,
   output logic [1:0] sat_weight_calc_enable,
   output logic rate_channel_enable,
   output logic [1:0] rate_channel_source
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////
   // writable registers
   logic [4:0] en_r, next_en_r;
   logic [3:0] win_r, next_win_r;
   logic [6:0] pthr_r, next_pthr_r;
   logic [6:0] sthr_r, next_sthr_r;
   logic [4:0] slen_r, next_slen_r;
   logic [3:0] found_r, next_found_r;
   logic [3:0] loss_r, next_loss_r;
   logic [7:0] polyl_r, next_polyl_r;
   logic [3:0] polyh_r, next_polyh_r;
   tfs_pkg::tfs_format_t fmt_r, next_fmt_r;
   logic fallb_r, next_fallb_r;
   logic [7:0] wen_r, next_wen_r;
   logic [2:0] rate_r, next_rate_r;
   always_comb begin
      next_en_r = en_r;
      next_win_r = win_r;
      next_pthr_r = pthr_r;
      next_sthr_r = sthr_r;
      next_slen_r = slen_r;
      next_found_r = found_r;
      next_loss_r = loss_r;
      next_polyl_r = polyl_r;
      next_polyh_r = polyh_r;
      next_fmt_r = fmt_r;
      next_fallb_r = fallb_r;
      next_wen_r = wen_r;
      next_rate_r = rate_r;
      if (reg_write) begin
         case (reg_addr)
            `TFS_A_TERR_EN: next_en_r = reg_wdata[4:0];
            `TFS_A_TERR_WIN: next_win_r = reg_wdata[3:0];
            `TFS_A_TERR_PTHR: next_pthr_r = reg_wdata[6:0];
            `TFS_A_TERR_STHR: next_sthr_r = reg_wdata[6:0];
            `TFS_A_TERR_SLEN: next_slen_r = reg_wdata[4:0];
            `TFS_A_TERR_FOUND: next_found_r = reg_wdata[3:0];
            `TFS_A_TERR_LOSS: next_loss_r = reg_wdata[3:0];
            `TFS_A_TERR_POLYL: next_polyl_r = reg_wdata;
            `TFS_A_TERR_POLYH: next_polyh_r = reg_wdata[3:0];
            `TFS_A_TERR_FMT: next_fmt_r = reg_wdata[3:0];
            `TFS_A_TERR_FALLB: next_fallb_r = reg_wdata[0];
            `TFS_A_SAT_WEN: next_wen_r = reg_wdata;
            `TFS_A_RATE_CTRL: next_rate_r = reg_wdata[2:0];
            default: ;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         en_r <= `TFS_R_TERR_EN;
         win_r <= `TFS_R_TERR_WIN;
         pthr_r <= `TFS_R_TERR_PTHR;
         sthr_r <= `TFS_R_TERR_STHR;
         slen_r <= `TFS_R_TERR_SLEN;
         found_r <= `TFS_R_TERR_FOUND;
         loss_r <= `TFS_R_TERR_LOSS;
         polyl_r <= `TFS_R_TERR_POLYL;
         polyh_r <= `TFS_R_TERR_POLYH;
         fmt_r <= `TFS_R_TERR_FMT;
         fallb_r <= `TFS_R_TERR_FALLB;
         wen_r <= `TFS_R_SAT_WEN;
         rate_r <= `TFS_R_RATE_CTRL;
      end else begin
         en_r <= next_en_r;
         win_r <= next_win_r;
         pthr_r <= next_pthr_r;
         sthr_r <= next_sthr_r;
         slen_r <= next_slen_r;
         found_r <= next_found_r;
         loss_r <= next_loss_r;
         polyl_r <= next_polyl_r;
         polyh_r <= next_polyh_r;
         fmt_r <= next_fmt_r;
         fallb_r <= next_fallb_r;
         wen_r <= next_wen_r;
         rate_r <= next_rate_r;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // terrestrial sync tracker
   tfs_pkg::tfs_track_t st, next_st;
   logic [4:0] slot_cnt, next_slot_cnt;
   logic [3:0] hit_cnt, next_hit_cnt;
   logic [3:0] miss_cnt, next_miss_cnt;
   logic restart, next_restart;
   logic pre_hit, sync_hit, slot_used;
   // presync hit at or above threshold
   assign pre_hit = terr_corr_mag >= pthr_r;
   // sync hit at or above threshold
   assign sync_hit = terr_corr_mag >= sthr_r;
   // once found, only slots inside the window count
   assign slot_used = terr_marker_slot && en_r[0] && (st == tfs_pkg::TFS_ST_HUNT || terr_in_window);
   always_comb begin
      next_st = st;
      next_slot_cnt = slot_cnt;
      next_hit_cnt = hit_cnt;
      next_miss_cnt = miss_cnt;
      next_restart = 1'b0;
      if (slot_used) begin
         case (st)
            tfs_pkg::TFS_ST_HUNT: begin
               if (pre_hit) begin
                  next_st = tfs_pkg::TFS_ST_PRE;
                  next_slot_cnt = 5'h0;
                  next_hit_cnt = 4'h0;
               end
            end
            tfs_pkg::TFS_ST_PRE: begin
               // found count saturates at loss limit
               if (sync_hit && hit_cnt < loss_r) next_hit_cnt = hit_cnt + 4'h1;
               next_slot_cnt = slot_cnt + 5'h1;
               // judged after the programmed number of positions
               if (next_slot_cnt >= slen_r) begin
                  if (next_hit_cnt < found_r) begin
                     next_st = tfs_pkg::TFS_ST_HUNT;
                     next_restart = 1'b1;
                  end else begin
                     next_st = tfs_pkg::TFS_ST_LOCK;
                     next_miss_cnt = 4'h0;
                  end
               end
            end
            tfs_pkg::TFS_ST_LOCK: begin
               if (sync_hit) next_miss_cnt = 4'h0;
               else next_miss_cnt = miss_cnt + 4'h1;
               // consecutive misses reaching limit restart search
               if (!sync_hit && next_miss_cnt >= loss_r) begin
                  next_restart = 1'b1;
                  next_st = fallb_r ? tfs_pkg::TFS_ST_PRE : tfs_pkg::TFS_ST_HUNT;
                  next_slot_cnt = 5'h0;
                  next_hit_cnt = 4'h0;
               end
            end
            default: next_st = tfs_pkg::TFS_ST_HUNT;
         endcase
      end
      if (!en_r[0]) next_st = tfs_pkg::TFS_ST_HUNT;
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st <= tfs_pkg::TFS_ST_HUNT;
         slot_cnt <= 5'h0;
         hit_cnt <= 4'h0;
         miss_cnt <= 4'h0;
         restart <= 1'b0;
      end else begin
         st <= next_st;
         slot_cnt <= next_slot_cnt;
         hit_cnt <= next_hit_cnt;
         miss_cnt <= next_miss_cnt;
         restart <= next_restart;
      end
   end
   a_restart_on_slot: assert property (terr_restart_search |-> $past(terr_marker_slot))
      else $error("restart pulse without a marker slot");
   a_restart_unlocks: assert property (terr_restart_search |-> st != tfs_pkg::TFS_ST_LOCK)
      else $error("tracker still locked after a restart");
   a_found_capped: assert property ($changed(hit_cnt) |-> hit_cnt <= $past(loss_r))
      else $error("found count passed the loss limit");
   c_tracker_lock: cover property (st == tfs_pkg::TFS_ST_LOCK);
   c_fallback_presync: cover property (terr_restart_search && st == tfs_pkg::TFS_ST_PRE);
   c_restart_hunt: cover property (terr_restart_search && st == tfs_pkg::TFS_ST_HUNT);
   logic [2:0] terr_state;
   always_comb begin
      case (st)
         tfs_pkg::TFS_ST_PRE: terr_state = {tfs_pkg::TFS_T_PRESYNC, 1'b0};
         tfs_pkg::TFS_ST_LOCK: terr_state = {tfs_pkg::TFS_T_SYNC, 1'b1};
         default: terr_state = {(restart ? tfs_pkg::TFS_T_UNLOCK : tfs_pkg::TFS_T_IDLE), 1'b0};
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // terrestrial formatter
   logic [DATA_W-1:0] fi, fq, next_out_i, next_out_q;
   function automatic logic [DATA_W-1:0] fmt_word(input logic [DATA_W-1:0] w,
                                                  input tfs_pkg::tfs_format_t f);
      logic [DATA_W-1:0] v;
      v = f.map_invert ? ~w : w;
      if (f.limiter) v = v[DATA_W-1] ? {DATA_W{1'b1}} : {v[DATA_W-2:0], 1'b0};
      // offset binary flips the sign bit
      if (f.offset_binary) v[DATA_W-1] = ~v[DATA_W-1];
      return v;
   endfunction : fmt_word
   always_comb begin
      fi = fmt_r.quadrature_swap ? terr_data_q : terr_data_i;
      fq = fmt_r.quadrature_swap ? terr_data_i : terr_data_q;
      next_out_i = terr_out_i;
      next_out_q = terr_out_q;
      if (terr_data_valid && en_r[1]) begin
         next_out_i = fmt_word(fi, fmt_r);
         next_out_q = fmt_word(fq, fmt_r);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // outputs and read mux
   logic [7:0] next_rdata;
   logic [1:0] next_zero;
   logic next_rate_en;
   always_comb begin
      // zero weights on enabled invalid pattern or slip
      next_zero[0] = (wen_r[3] & sat_invalid_pattern[0]) | (wen_r[2] & sat_cycle_slip[0]);
      next_zero[1] = (wen_r[7] & sat_invalid_pattern[1]) | (wen_r[6] & sat_cycle_slip[1]);
      next_rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            `TFS_A_SAT1_PHASE: next_rdata = {6'h00, sat1_phase_in};
            `TFS_A_SAT2_STATE: next_rdata = {1'b0, sat2_state_in};
            `TFS_A_SAT2_MISS: next_rdata = {4'h0, sat2_miss_in};
            `TFS_A_SAT2_MCRE: next_rdata = sat2_corr_in.marker_re;
            `TFS_A_SAT2_MCIM: next_rdata = sat2_corr_in.marker_im;
            `TFS_A_SAT2_PCRE: next_rdata = {1'b0, sat2_corr_in.pattern_re};
            `TFS_A_SAT2_PCIM: next_rdata = {1'b0, sat2_corr_in.pattern_im};
            `TFS_A_SAT2_PHASE: next_rdata = {6'h00, sat2_phase_in};
            `TFS_A_TERR_EN: next_rdata = {3'h0, en_r};
            `TFS_A_TERR_WIN: next_rdata = {4'h0, win_r};
            `TFS_A_TERR_PTHR: next_rdata = {1'b0, pthr_r};
            `TFS_A_TERR_STHR: next_rdata = {1'b0, sthr_r};
            `TFS_A_TERR_SLEN: next_rdata = {3'h0, slen_r};
            `TFS_A_TERR_FOUND: next_rdata = {4'h0, found_r};
            `TFS_A_TERR_LOSS: next_rdata = {4'h0, loss_r};
            `TFS_A_TERR_POLYL: next_rdata = polyl_r;
            `TFS_A_TERR_POLYH: next_rdata = {4'h0, polyh_r};
            `TFS_A_TERR_FMT: next_rdata = {4'h0, fmt_r};
            `TFS_A_TERR_STATE: next_rdata = {5'h00, terr_state};
            `TFS_A_TERR_FCNT: next_rdata = {4'h0, hit_cnt};
            `TFS_A_TERR_MCRE: next_rdata = terr_corr_re;
            `TFS_A_TERR_MCIM: next_rdata = terr_corr_im;
            `TFS_A_TERR_PHASE: next_rdata = {6'h00, terr_phase_in};
            `TFS_A_TERR_FALLB: next_rdata = {7'h00, fallb_r};
            `TFS_A_SAT_WEN: next_rdata = wen_r;
            `TFS_A_SAT_WST: next_rdata = {6'h00, sat_weight_active};
            `TFS_A_RATE_CTRL: next_rdata = {5'h00, rate_r};
            default: next_rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
         terr_out_i <= '0;
         terr_out_q <= '0;
         terr_out_valid <= 1'b0;
         sat_weight_zero <= 2'h0;
         terr_restart_search <= 1'b0;
         rate_channel_enable <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         terr_out_i <= next_out_i;
         terr_out_q <= next_out_q;
         terr_out_valid <= terr_data_valid & en_r[1];
         sat_weight_zero <= next_zero;
         terr_restart_search <= next_restart;
         rate_channel_enable <= next_rate_en;
      end
   end
   a_out_valid_lag: assert property (terr_out_valid == $past(terr_data_valid && en_r[1]))
      else $error("formatter valid not one cycle after input valid");
   a_weight_zero: assert property ($past(wen_r[3] & sat_invalid_pattern[0])
      |-> sat_weight_zero[0]) else $error("weight zeroing missed an invalid pattern");
   a_rate_rfu_off: assert property (rate_channel_enable |->
      rate_channel_source != `TFS_RATE_SRC_RFU) else $error("rate channel on with rfu source");
   // registers feed these directly, so they are flop outputs
   assign terr_enables = en_r;
   assign terr_window_width = win_r;
   assign terr_poly = {polyh_r, polyl_r};
   // fifo and calc enables per satellite
   assign sat_weight_fifo_enable = {wen_r[5], wen_r[1]};
   assign sat_weight_calc_enable = {wen_r[4], wen_r[0]};
   // reserved source keeps the channel off
   assign next_rate_en = next_rate_r[0] & (next_rate_r[2:1] != `TFS_RATE_SRC_RFU);
   assign rate_channel_source = rate_r[2:1];
endmodule : tfs_frame_sync_ctrl
`default_nettype wire

// File: verification/tfs_demod_model.sv
// upstream demodulator model: terrestrial marker slot stream
`timescale 1ns/1ps
`default_nettype none
module tfs_demod_model (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // bench knobs
   input wire logic run,
   input wire logic [6:0] slot_mag,
   // marker stream
   output logic terr_marker_slot,
   output logic terr_in_window,
   output logic [6:0] terr_corr_mag,
   output logic [7:0] slot_count
);
   logic [2:0] gap;
   // one predicted slot every eight cycles; off-slot magnitude is inverted so stale data never helps
   always_ff @(posedge clock) begin
      if (!resetn) begin
         gap <= 3'h0;
         terr_marker_slot <= 1'b0;
         terr_in_window <= 1'b0;
         terr_corr_mag <= 7'h00;
         slot_count <= 8'h00;
      end else begin
         gap <= gap + 3'h1;
         terr_marker_slot <= run && (gap == 3'h7);
         terr_in_window <= run && (gap == 3'h7);
         terr_corr_mag <= (run && gap == 3'h7) ? slot_mag : ~slot_mag;
         if (run && gap == 3'h7) begin
            slot_count <= slot_count + 8'h01;
         end
      end
   end
endmodule : tfs_demod_model
`default_nettype wire

// File: verification/tfs_frame_sync_control_test.sv
// self-checking bench for the tdm frame sync control bank
`timescale 1ns/1ps
`default_nettype none
module tfs_frame_sync_control_test;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_rdata;
   tfs_pkg::tfs_sat_state_t sat2_state = '0;
   tfs_pkg::tfs_corr_t sat2_corr = '0;
   logic [3:0] sat2_miss = 4'h0;
   logic [1:0] sat1_phase = 2'h0;
   logic [1:0] sat2_phase = 2'h0;
   logic [1:0] terr_phase = 2'h0;
   logic [1:0] invalid_pat = 2'h0;
   logic [1:0] slip = 2'h0;
   logic [1:0] weight_active = 2'h0;
   logic [7:0] corr_re = 8'h00;
   logic [7:0] corr_im = 8'h00;
   logic data_valid = 1'b0;
   logic [7:0] data_i = 8'h00;
   logic [7:0] data_q = 8'h00;
   logic [6:0] slot_mag = 7'h00;
   logic slot, in_win;
   logic [6:0] mag;
   logic [7:0] slot_count;
   logic [4:0] terr_enables;
   logic [3:0] win_w;
   logic [11:0] poly;
   logic restart, out_valid, rate_en;
   logic [7:0] out_i, out_q;
   logic [1:0] w_zero, w_fifo, w_calc, rate_src;
   int n_errors = 0;
   int comparisons = 0;
   int restarts = 0;
   // read/write registers: address, reset value, implemented bits
   localparam logic [9:0] RA [13] = '{10'h22d, 10'h22e, 10'h22f, 10'h230, 10'h231, 10'h232,
      10'h233, 10'h234, 10'h235, 10'h236, 10'h23f, 10'h240, 10'h250};
   localparam logic [7:0] RV [13] = '{8'h1f, 8'h07, 8'h2c, 8'h28, 8'h03, 8'h02, 8'h0b, 8'h05,
      8'h08, 8'h00, 8'h01, 8'hff, 8'h00};
   localparam logic [7:0] RM [13] = '{8'h1f, 8'h0f, 8'h7f, 8'h7f, 8'h1f, 8'h0f, 8'h0f, 8'hff,
      8'h0f, 8'h0f, 8'h01, 8'hff, 8'h07};

   tfs_demod_model tfs_demod_model_i (.clock(clock), .resetn(resetn), .run(1'b1),
      .slot_mag(slot_mag), .terr_marker_slot(slot), .terr_in_window(in_win),
      .terr_corr_mag(mag), .slot_count(slot_count));
   tfs_frame_sync_ctrl tfs_frame_sync_ctrl_i (.clock(clock), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .sat2_state_in(sat2_state), .sat2_miss_in(sat2_miss),
      .sat2_corr_in(sat2_corr), .sat1_phase_in(sat1_phase), .sat2_phase_in(sat2_phase),
      .sat_invalid_pattern(invalid_pat), .sat_cycle_slip(slip),
      .sat_weight_active(weight_active), .terr_marker_slot(slot), .terr_in_window(in_win),
      .terr_corr_mag(mag), .terr_corr_re(corr_re), .terr_corr_im(corr_im),
      .terr_phase_in(terr_phase), .terr_data_valid(data_valid), .terr_data_i(data_i),
      .terr_data_q(data_q), .terr_enables(terr_enables), .terr_window_width(win_w),
      .terr_poly(poly), .terr_restart_search(restart), .terr_out_i(out_i), .terr_out_q(out_q),
      .terr_out_valid(out_valid), .sat_weight_zero(w_zero), .sat_weight_fifo_enable(w_fifo),
      .sat_weight_calc_enable(w_calc), .rate_channel_enable(rate_en),
      .rate_channel_source(rate_src));

   initial begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      if (restart === 1'b1) restarts++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string name);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 check(name, {4'h0, reg_rdata}, {4'h0, exp});
   endtask : rd
   task automatic do_reset();
      resetn <= 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
   endtask : do_reset
   task automatic slots(input int n);
      logic [7:0] t;
      t = slot_count + n[7:0];
      for (int k = 0; k < n * 20 && slot_count !== t; k++) @(posedge clock);
      repeat (3) @(posedge clock);
      #1 check("slot wait", {4'h0, slot_count}, {4'h0, t});
   endtask : slots
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset_values();
      for (int k = 0; k < 13; k++) rd(RA[k], RV[k], "reset value");
      check("enables out", {7'h0, terr_enables}, 12'h01f);
      check("window out", {8'h0, win_w}, 12'h007);
      check("poly out", poly, 12'h805);
      rd(10'h227, 8'h00, "unmapped read");
   endtask : test_reset_values
   task automatic test_write_masks();
      for (int k = 0; k < 13; k++) wr(RA[k], 8'hff);
      wr(10'h227, 8'hff);
      for (int k = 0; k < 13; k++) rd(RA[k], RM[k], "write ones");
      check("poly ones", poly, 12'hfff);
      rd(10'h227, 8'h00, "unmapped write");
      do_reset();
   endtask : test_write_masks
   task automatic test_readback();
      sat2_state <= '{search: 2'h2, dropout: 2'h1, status: 2'h3, lock: 1'b0};
      sat2_miss <= 4'hb;
      sat2_corr <= '{marker_re: 8'ha5, marker_im: 8'h3c, pattern_re: 7'h55, pattern_im: 7'h2a};
      corr_re <= 8'h96;
      corr_im <= 8'h69;
      weight_active <= 2'h2;
      wr(10'h225, 8'hff);
      rd(10'h225, 8'h4e, "sat2 state");
      rd(10'h226, 8'h0b, "sat2 misses");
      rd(10'h228, 8'ha5, "marker re");
      rd(10'h229, 8'h3c, "marker im");
      rd(10'h22a, 8'h55, "pattern re");
      rd(10'h22b, 8'h2a, "pattern im");
      rd(10'h23a, 8'h96, "terr re");
      rd(10'h23b, 8'h69, "terr im");
      rd(10'h241, 8'h02, "weight state");
      for (int k = 0; k < 4; k++) begin
         sat1_phase <= k[1:0];
         sat2_phase <= ~k[1:0];
         terr_phase <= k[1:0];
         rd(10'h224, {6'h0, k[1:0]}, "sat1 phase");
         rd(10'h22c, {6'h0, ~k[1:0]}, "sat2 phase");
         rd(10'h23c, {6'h0, k[1:0]}, "terr phase");
      end
   endtask : test_readback
   task automatic fmt_case(input logic [3:0] f, input logic [7:0] i, q, ei, eq);
      wr(10'h236, {4'h0, f});
      @(posedge clock);
      data_valid <= 1'b1;
      data_i <= i;
      data_q <= q;
      @(posedge clock);
      data_valid <= 1'b0;
      #1 check("out valid", {11'h0, out_valid}, 12'h001);
      check("out i", {4'h0, out_i}, {4'h0, ei});
      check("out q", {4'h0, out_q}, {4'h0, eq});
   endtask : fmt_case
   task automatic test_weights_rate();
      check("fifo en", {10'h0, w_fifo}, 12'h003);
      wr(10'h240, 8'h5a);
      check("fifo en", {10'h0, w_fifo}, 12'h001);
      check("calc en", {10'h0, w_calc}, 12'h002);
      invalid_pat <= 2'h3;
      repeat (2) @(posedge clock);
      #1 check("zero invalid", {10'h0, w_zero}, 12'h001);
      invalid_pat <= 2'h0;
      slip <= 2'h3;
      repeat (2) @(posedge clock);
      #1 check("zero slip", {10'h0, w_zero}, 12'h002);
      slip <= 2'h0;
      wr(10'h250, 8'h03);
      check("rate en", {9'h0, rate_src, rate_en}, 12'h003);
      wr(10'h250, 8'h05);
      check("rate en", {9'h0, rate_src, rate_en}, 12'h005);
      wr(10'h250, 8'h07);
      check("rate rfu", {9'h0, rate_src, rate_en}, 12'h006);
   endtask : test_weights_rate
   task automatic test_tracker();
      restarts = 0;
      slot_mag <= 7'h2c;
      slots(1);
      rd(10'h237, 8'h02, "presync");
      slot_mag <= 7'h28;
      slots(3);
      rd(10'h237, 8'h05, "sync");
      rd(10'h239, 8'h03, "found count");
      slot_mag <= 7'h00;
      slots(10);
      check("no restart", restarts[11:0], 12'h000);
      slots(1);
      check("loss restart", restarts[11:0], 12'h001);
      rd(10'h237, 8'h02, "fallback");
      rd(10'h239, 8'h00, "found count");
      slots(3);
      check("few found", restarts[11:0], 12'h002);
      rd(10'h237, 8'h00, "hunt idle");
   endtask : test_tracker
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #(40 * 8000);
      n_errors++;
      finish_test();
   end
   initial begin
      do_reset();
      test_reset_values();
      test_write_masks();
      test_reset_values();
      test_readback();
      fmt_case(4'h2, 8'h85, 8'h21, 8'hff, 8'h42);
      fmt_case(4'h1, 8'h11, 8'h22, 8'h22, 8'h11);
      fmt_case(4'h4, 8'h05, 8'h05, 8'h85, 8'h85);
      fmt_case(4'h8, 8'h0f, 8'hf0, 8'hf0, 8'h0f);
      test_weights_rate();
      test_tracker();
      finish_test();
   end
endmodule : tfs_frame_sync_control_test
`default_nettype wire
